// ### src/bolr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Floor code one is 2.9 V, 50 mV steps
// - Floor code resets to 01001, 3.3 V
// - Ceiling code zero 2.85 V, 50 mV steps
// - Ceiling resets 01110, reserved bits zero
// - Bit five disables current limit, resets zero
// - Bit four low: soft-start uses limit code
// - Bit four high: soft-start fixed 1250 mA
// - Limit code 500 mA steps, resets 1111
module bolr_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register access from the serial front end
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rvalid,
	// Decoded settings for the regulator
	output bolr_pkg::bolr_setting_t setting,
	// Raw fields
	output logic [4:0] floor_code,
	output logic [4:0] ceiling_code,
	output logic limit_disable_bit,
	output logic soft_start_fixed,
	output logic [3:0] limit_code_field
);
	// Stored register fields
	logic [4:0] floor_reg, floor_next;
	logic [4:0] ceiling_reg, ceiling_next;
	logic dis_reg, dis_next;
	logic ss_reg, ss_next;
	logic [3:0] code_reg, code_next;
	// Read port and decoded settings
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	bolr_pkg::bolr_setting_t set_reg, set_next;
	logic [12:0] limit_ma;

	// Write decode; reserved bits are not stored so they read zero
	always_comb begin
		floor_next = floor_reg;
		ceiling_next = ceiling_reg;
		dis_next = dis_reg;
		ss_next = ss_reg;
		code_next = code_reg;
		if (wr_en) begin
			unique case (addr)
				bolr_pkg::FLOOR_OFFSET: begin
					floor_next = wdata[4:0];
				end
				bolr_pkg::CEILING_OFFSET: begin
					ceiling_next = wdata[4:0];
				end
				bolr_pkg::LIMIT_OFFSET: begin
					dis_next = wdata[bolr_pkg::LIMIT_DISABLE_POS];
					ss_next = wdata[bolr_pkg::SOFT_START_POS];
					code_next = wdata[3:0];
				end
				default: begin
					// Unmapped address, write dropped
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = rd_en;
		if (rd_en) begin
			unique case (addr)
				bolr_pkg::FLOOR_OFFSET: begin
					rdata_next = {3'h0, floor_reg};
				end
				bolr_pkg::CEILING_OFFSET: begin
					rdata_next = {3'h0, ceiling_reg};
				end
				bolr_pkg::LIMIT_OFFSET: begin
					rdata_next = {2'h0, dis_reg, ss_reg, code_reg};
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// Decode codes into targets; 1101 follows the step pattern
	always_comb begin
		limit_ma = bolr_pkg::LIMIT_BASE_MA
			+ 13'(code_reg - bolr_pkg::LIMIT_CODE_MIN)
			* bolr_pkg::LIMIT_STEP_MA;
		set_next.floor_mv = bolr_pkg::FLOOR_BASE_MV
			+ 13'(floor_reg - 5'h01) * bolr_pkg::VOLT_STEP_MV;
		set_next.ceiling_mv = bolr_pkg::CEILING_BASE_MV
			+ 13'(ceiling_reg) * bolr_pkg::VOLT_STEP_MV;
		set_next.limit_enable = ~dis_reg;
		set_next.limit_ma = limit_ma;
		if (ss_reg) begin
			set_next.soft_start_ma = bolr_pkg::SOFT_START_FIXED_MA;
		end else begin
			set_next.soft_start_ma = limit_ma;
		end
	end

	// Register all state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			floor_reg <= bolr_pkg::FLOOR_RESET;
			ceiling_reg <= bolr_pkg::CEILING_RESET;
			dis_reg <= bolr_pkg::LIMIT_DISABLE_RESET;
			ss_reg <= bolr_pkg::SOFT_START_FIXED_RESET;
			code_reg <= bolr_pkg::LIMIT_CODE_RESET;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			set_reg <= '0;
		end else begin
			floor_reg <= floor_next;
			ceiling_reg <= ceiling_next;
			dis_reg <= dis_next;
			ss_reg <= ss_next;
			code_reg <= code_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			set_reg <= set_next;
		end
	end

	// Outputs straight from flip-flops
	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;
	assign setting = set_reg;
	assign floor_code = floor_reg;
	assign ceiling_code = ceiling_reg;
	assign limit_disable_bit = dis_reg;
	assign soft_start_fixed = ss_reg;
	assign limit_code_field = code_reg;

	// Ceiling write lands in the field next cycle
	ceiling_write_a: assert property (@(posedge clk)
		disable iff (!resetn)
		wr_en && addr == bolr_pkg::CEILING_OFFSET
		|=> ceiling_code == $past(wdata[4:0]))
		else $error("Ceiling field not written");
	// Floor write lands in the field next cycle
	floor_write_a: assert property (@(posedge clk)
		disable iff (!resetn)
		wr_en && addr == bolr_pkg::FLOOR_OFFSET
		|=> floor_code == $past(wdata[4:0]))
		else $error("Floor field not written");
	// Limit write lands in all three fields
	limit_write_a: assert property (@(posedge clk)
		disable iff (!resetn)
		wr_en && addr == bolr_pkg::LIMIT_OFFSET
		|=> limit_disable_bit == $past(wdata[5])
		&& soft_start_fixed == $past(wdata[4])
		&& limit_code_field == $past(wdata[3:0]))
		else $error("Limit fields not written");
	// Ceiling readback has zero reserved bits
	ceiling_read_a: assert property (@(posedge clk)
		disable iff (!resetn)
		rd_en && addr == bolr_pkg::CEILING_OFFSET
		|=> rvalid && rdata[7:5] == 3'h0)
		else $error("Ceiling reserved bits not zero");
	// Floor readback returns the stored code
	floor_read_a: assert property (@(posedge clk)
		disable iff (!resetn)
		rd_en && addr == bolr_pkg::FLOOR_OFFSET
		|=> rvalid && rdata == {3'h0, $past(floor_code)})
		else $error("Floor readback wrong");
	// Limit readback returns the stored fields
	limit_read_a: assert property (@(posedge clk)
		disable iff (!resetn)
		rd_en && addr == bolr_pkg::LIMIT_OFFSET
		|=> rvalid && rdata == {2'h0, $past(limit_disable_bit),
		$past(soft_start_fixed), $past(limit_code_field)})
		else $error("Limit readback wrong");
	// Floor target follows 50 mV steps; skips the reset edge
	floor_scale_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) |-> setting.floor_mv
		== 13'd2900 + 13'($past(floor_code) - 5'h01) * 13'd50)
		else $error("Floor target wrong");
	// Ceiling target follows 50 mV steps
	ceiling_scale_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) |-> setting.ceiling_mv
		== 13'd2850 + 13'($past(ceiling_code)) * 13'd50)
		else $error("Ceiling target wrong");
	// Disable bit turns off the limit
	limit_off_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn)
		|-> setting.limit_enable == !$past(limit_disable_bit))
		else $error("Limit enable mismatch");
	// Fixed soft-start current when bit four set
	ss_fixed_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) && $past(soft_start_fixed)
		|-> setting.soft_start_ma == 13'd1250)
		else $error("Soft-start not 1250 mA");
	// Soft-start tracks limit when bit four clear
	ss_track_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) && !$past(soft_start_fixed)
		|-> setting.soft_start_ma == setting.limit_ma)
		else $error("Soft-start not tracking limit");
	// Lowest defined code gives 1500 mA
	code_1500_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) && $past(limit_code_field) == 4'h8
		|-> setting.limit_ma == 13'd1500)
		else $error("Code 1000 not 1500 mA");
	// Code 1101 gives 4000 mA
	code_4000_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) && $past(limit_code_field) == 4'hd
		|-> setting.limit_ma == 13'd4000)
		else $error("Code 1101 not 4000 mA");
	// Top code gives 5000 mA
	code_5000_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(resetn) && $past(limit_code_field) == 4'hf
		|-> setting.limit_ma == 13'd5000)
		else $error("Code 1111 not 5000 mA");
	// Floor reset value
	floor_reset_a: assert property (@(posedge clk)
		$rose(resetn) |-> floor_code == 5'h09)
		else $error("Floor reset wrong");
	// Ceiling reset value
	ceiling_reset_a: assert property (@(posedge clk)
		$rose(resetn) |-> ceiling_code == 5'h0e)
		else $error("Ceiling reset wrong");
	// Limit comes out of reset enabled
	dis_reset_a: assert property (@(posedge clk)
		$rose(resetn) |-> !limit_disable_bit)
		else $error("Disable bit reset wrong");
	// Soft-start comes out of reset fixed
	ss_reset_a: assert property (@(posedge clk)
		$rose(resetn) |-> soft_start_fixed)
		else $error("Soft-start bit reset wrong");
	// Limit code comes out of reset at the top code
	code_reset_a: assert property (@(posedge clk)
		$rose(resetn) |-> limit_code_field == 4'hf)
		else $error("Limit code reset wrong");
endmodule : bolr_regs
`default_nettype wire

// ### src/bolr_pkg.sv
`default_nettype none
package bolr_pkg;
	// Register offsets
	localparam logic [7:0] FLOOR_OFFSET = 8'h02;
	localparam logic [7:0] CEILING_OFFSET = 8'h03;
	localparam logic [7:0] LIMIT_OFFSET = 8'h04;
	// Reset values
	localparam logic [4:0] FLOOR_RESET = 5'h09;
	localparam logic [4:0] CEILING_RESET = 5'h0e;
	localparam logic LIMIT_DISABLE_RESET = 1'b0;
	localparam logic SOFT_START_FIXED_RESET = 1'b1;
	localparam logic [3:0] LIMIT_CODE_RESET = 4'hf;
	// Field positions in the current-limit register
	localparam int LIMIT_DISABLE_POS = 5;
	localparam int SOFT_START_POS = 4;
	// Voltage scales in millivolts
	localparam logic [12:0] FLOOR_BASE_MV = 13'h0b54;
	localparam logic [12:0] CEILING_BASE_MV = 13'h0b22;
	localparam logic [12:0] VOLT_STEP_MV = 13'h0032;
	// Current scales in milliamps
	localparam logic [12:0] LIMIT_BASE_MA = 13'h05dc;
	localparam logic [12:0] LIMIT_STEP_MA = 13'h01f4;
	localparam logic [3:0] LIMIT_CODE_MIN = 4'h8;
	localparam logic [12:0] SOFT_START_FIXED_MA = 13'h04e2;

	// Settings handed to the analog side
	typedef struct packed {
		logic [12:0] floor_mv;
		logic [12:0] ceiling_mv;
		logic limit_enable;
		logic [12:0] limit_ma;
		logic [12:0] soft_start_ma;
	} bolr_setting_t;
endpackage : bolr_pkg
`default_nettype wire

// ### testbench/bolr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host model: one-cycle strobes, taken at the next edge
module bolr_host (
	// Clock
	input wire logic clk,
	// Register strobes
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	initial {wr_en, rd_en, addr, wdata} = '0;
	// Write; reserved bits always sent as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		addr <= a;
		wdata <= d & ((a == 8'h04) ? 8'h3f : 8'h1f);
	endtask : wr
	// Read request
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		addr <= a;
	endtask : rd
	// Drop both strobes
	task automatic idle();
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask : idle
endmodule : bolr_host
`default_nettype wire

// ### testbench/boost_output_and_limit_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module boost_output_and_limit_regs_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr_en, rd_en, rvalid;
	logic [7:0] addr, wdata, rdata;
	bolr_pkg::bolr_setting_t setting;
	logic [7:0] exp_q [$]; // Expected read data
	int fail_count = 0;
	int cmp_count = 0;
	int c, f, v, b;
	// 100 MHz clock
	always #5 clk = ~clk;
	bolr_host bolr_host_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata));
	bolr_regs bolr_regs_inst (.clk(clk), .resetn(resetn), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
		.rvalid(rvalid), .setting(setting), .floor_code(),
		.ceiling_code(), .limit_disable_bit(), .soft_start_fixed(),
		.limit_code_field());
	// Compare and count
	task automatic check(string n, logic [12:0] s, logic [12:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : check
	// Verdict
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// Note the answer, then ask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bolr_host_inst.rd(a);
	endtask : rd
	// Idle until decoded settings have landed
	task automatic settle();
		bolr_host_inst.idle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle
	// Read monitor: oldest note against each answer
	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() > 0) check("rdata", 13'(rdata), 13'(exp_q.pop_front()));
			else check("spurious rvalid", 13'h1, 13'h0);
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'h4072));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		bolr_host_inst.wr(8'h07, 8'($urandom));
		rd(8'h02, 8'h09);
		rd(8'h03, 8'h0e);
		rd(8'h04, 8'h1f);
		rd(8'h07, 8'h00);
		settle();
		check("floor", setting.floor_mv, 13'd3300);
		check("ceil", setting.ceiling_mv, 13'd3550);
		check("soft", setting.soft_start_ma, 13'd1250);
		check("lim", setting.limit_ma, 13'd5000);
		check("en", 13'(setting.limit_enable), 13'h1);
		$display("test reset done");
		// Every defined limit code (1000 to 1111), random mode bits, back-to-back readback
		for (c = 8; c < 16; c++) begin
			v = ($urandom & 32'h30) | c;
			bolr_host_inst.wr(8'h04, 8'(v));
			rd(8'h04, 8'(v));
			settle();
			b = 1500 + 500 * (c - 8);
			check("lim", setting.limit_ma, 13'(b));
			check("en", 13'(setting.limit_enable), 13'(!v[5]));
			check("soft", setting.soft_start_ma, v[4] ? 13'd1250 : 13'(b));
		end
		$display("test limit done");
		// All ceiling codes, all defined floor codes
		for (c = 0; c < 32; c++) begin
			f = c % 31 + 1;
			bolr_host_inst.wr(8'h03, 8'(c));
			bolr_host_inst.wr(8'h02, 8'(f));
			rd(8'h03, 8'(c));
			rd(8'h02, 8'(f));
			settle();
			check("ceil", setting.ceiling_mv, 13'(2850 + 50 * c));
			check("floor", setting.floor_mv, 13'(2900 + 50 * (f - 1)));
		end
		for (b = 0; b < 10 && exp_q.size() > 0; b++) @(posedge clk);
		if (exp_q.size() > 0) check("reads left", 13'h1, 13'h0);
		$display("test targets done");
		tally_and_finish();
	end
endmodule : boost_output_and_limit_regs_bench
`default_nettype wire
